//--- src/tcm_filt_if.sv
// interface carrying filtered channel levels from the pulse filter
`timescale 1ns/1ps
interface tcm_filt_if;
    logic raw_a;
    logic raw_b;
    logic lvl_a;
    logic lvl_b;
    modport filt (input raw_a, input raw_b, output lvl_a, output lvl_b);
    modport mon  (output raw_a, output raw_b, input lvl_a, input lvl_b);
endinterface : tcm_filt_if

//--- src/tcm_monitor.sv
// top of the dual channel torque cutoff monitor
`timescale 1ns/1ps
module tcm_monitor
    import tcm_pkg::*;
#(
    parameter int TICK_LEN  = TICK_CYCLES,
    parameter int DISC_LEN  = DISC_TICKS,
    parameter int PULSE_MAX = PULSE_CYCLES
)(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic safe_stop_channel_a,
    input  wire logic safe_stop_channel_b,
    input  wire logic pwm_running,
    input  wire logic err_ack,
    input  wire logic sensor_supply_en,
    output logic      driver_supply_en,
    output logic      drive_ctrl_en,
    output logic      torque_cutoff_state,
    output logic      disc_err,
    output logic      cutoff_pwm_err,
    output logic      sensor_supply_output
);
    // filtered channel levels come back from the pulse filter here
    tcm_filt_if       fif();
    tcm_state_t       st_r;
    tcm_state_t       st_nxt;
    logic [CNT_W-1:0] tick_r;
    logic [CNT_W-1:0] tick_nxt;
    logic [7:0]       disc_r;
    logic [7:0]       disc_nxt;
    logic             derr_r;
    logic             derr_nxt;
    logic             derr_set;
    logic             perr_r;
    logic             perr_nxt;
    logic             perr_set;
    logic             cut_req;
    logic             drv_r;
    logic             drv_nxt;
    logic             sup_r;
    logic             sup_nxt;
    logic             tick;
    logic             a;
    logic             b;

    // only the two channel pins can request cutoff
    assign fif.raw_a = safe_stop_channel_a;
    assign fif.raw_b = safe_stop_channel_b;
    assign a = fif.lvl_a;
    assign b = fif.lvl_b;

    tcm_pulse_filter #(
        .PULSE_MAX (PULSE_MAX)
    ) u_filt (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .fi  (fif)
    );

    // tick generator; the state machine steps only on it
    // a short TICK_LEN only speeds up benches; the default is 10 ms
    assign tick = (tick_r == CNT_W'(TICK_LEN - 1));
    always_comb
    begin
        tick_nxt = tick ? '0 : tick_r + 1'b1;
    end

    // state machine and discrepancy timer; errors leave as set events
    always_comb
    begin
        st_nxt   = st_r;
        disc_nxt = disc_r;
        derr_set = 1'b0;
        cut_req  = 1'b0;
        if (tick)
        begin
            case (st_r)
                TCM_RUN:
                begin
                    // both low at one tick counts as a simultaneous drop
                    if (!a && !b)
                    begin
                        st_nxt  = TCM_CUTOFF;
                        cut_req = 1'b1;
                    end
                    else if (a != b)
                    begin
                        st_nxt   = TCM_DISC;
                        disc_nxt = 8'h01;
                    end
                end
                TCM_DISC:
                begin
                    // the window is only resolved to one tick
                    if (a == b)
                    begin
                        disc_nxt = 8'h00;
                        if (!a)
                        begin
                            st_nxt  = TCM_CUTOFF;
                            cut_req = 1'b1;
                        end
                        else
                            st_nxt = TCM_RUN;
                    end
                    else if (disc_r >= 8'(DISC_LEN))
                    begin
                        derr_set = 1'b1;
                        st_nxt   = TCM_CUTOFF;
                        disc_nxt = 8'h00;
                    end
                    else
                        disc_nxt = disc_r + 8'h01;
                end
                TCM_CUTOFF:
                begin
                    // no standstill check here
                    if (a && b)
                        st_nxt = TCM_RUN;
                end
                default: st_nxt = TCM_CUTOFF;
            endcase
        end
    end

    // a cutoff request seen while modulation runs is an error
    assign perr_set = cut_req & pwm_running;

    // error latches: one ack clears both, but a set in that cycle wins
    always_comb
    begin
        derr_nxt = derr_r;
        perr_nxt = perr_r;
        if (err_ack)
        begin
            derr_nxt = 1'b0;
            perr_nxt = 1'b0;
        end
        if (derr_set)
            derr_nxt = 1'b1;
        if (perr_set)
            perr_nxt = 1'b1;
    end

    // hardware cutoff path is immediate, not tied to the tick
    always_comb
    begin
        drv_nxt = (a & b) & !(st_r == TCM_CUTOFF && !tick);
        sup_nxt = sensor_supply_en;
    end

    // tick counter
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tick_r <= '0;
        end
        else if (ce)
        begin
            tick_r <= tick_nxt;
        end
    end

    // state and timer; reset lands in cutoff so power-up is safe
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_r   <= TCM_CUTOFF;
            disc_r <= 8'h00;
        end
        else if (ce)
        begin
            st_r   <= st_nxt;
            disc_r <= disc_nxt;
        end
    end

    // error latches
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            derr_r <= 1'b0;
            perr_r <= 1'b0;
        end
        else if (ce)
        begin
            derr_r <= derr_nxt;
            perr_r <= perr_nxt;
        end
    end

    // driver and sensor supply flops
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            drv_r <= 1'b0;
            sup_r <= 1'b0;
        end
        else if (ce)
        begin
            drv_r <= drv_nxt;
            sup_r <= sup_nxt;
        end
    end

    // no cross-circuit check exists on the inputs
    // supply and control share one flop so they can never disagree
    assign driver_supply_en     = drv_r;
    assign drive_ctrl_en        = drv_r;

    // the reported state lags the hardware cutoff by up to a tick when both channels drop, and until the discrepancy timeout when one drops
    assign torque_cutoff_state  = (st_r == TCM_CUTOFF);

    // latched errors and the switched sensor supply
    assign disc_err             = derr_r;
    assign cutoff_pwm_err       = perr_r;
    assign sensor_supply_output = sup_r;
endmodule : tcm_monitor

//--- src/tcm_pkg.sv
// package of constants and types for the dual channel torque cutoff monitor
package tcm_pkg;
    localparam int CLK_HZ         = 50_000_000;
    localparam int TICK_MS        = 10;
    localparam int TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
    localparam int DISC_MS        = 100;
    localparam int DISC_TICKS     = DISC_MS / TICK_MS;
    localparam int PULSE_US       = 1000;
    localparam int PULSE_CYCLES   = CLK_HZ / 1_000_000 * PULSE_US;
    localparam int CNT_W          = 20;

    typedef enum logic [1:0] {
        TCM_RUN,
        TCM_DISC,
        TCM_CUTOFF
    } tcm_state_t;
endpackage : tcm_pkg

//--- src/tcm_pulse_filter.sv
// test pulse filter: a low must persist before it is believed
`timescale 1ns/1ps
module tcm_pulse_filter
    import tcm_pkg::*;
#(
    parameter int PULSE_MAX = PULSE_CYCLES
)(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    tcm_filt_if.filt  fi
);
    localparam logic [CNT_W-1:0] LIM = CNT_W'(PULSE_MAX);
    logic [1:0] raw;
    logic [1:0] lvl;

    assign raw = {fi.raw_b, fi.raw_a};

    // one filter per channel; a shared counter would let a pulse on one
    // channel hide a real drop on the other
    for (genvar i = 0; i < 2; i++)
    begin : g_ch
        logic [CNT_W-1:0] cnt_r;
        logic [CNT_W-1:0] cnt_nxt;
        logic             lvl_r;
        logic             lvl_nxt;

        // rising edges pass at once; falls must outlast a test pulse
        always_comb
        begin
            cnt_nxt = raw[i] ? '0 : ((cnt_r < LIM) ? cnt_r + 1'b1 : cnt_r);
            lvl_nxt = raw[i] | (cnt_r < LIM);
        end

        // register stage
        always_ff @(posedge clk)
        begin
            if (rst)
            begin
                cnt_r <= '0;
                lvl_r <= 1'b0;
            end
            else if (ce)
            begin
                cnt_r <= cnt_nxt;
                lvl_r <= lvl_nxt;
            end
        end

        assign lvl[i] = lvl_r;
    end

    assign fi.lvl_a = lvl[0];
    assign fi.lvl_b = lvl[1];
endmodule : tcm_pulse_filter

//--- verif/tcm_chk.sv
// port assertions for the torque cutoff monitor
`timescale 1ns/1ps
module tcm_chk #(
    parameter int PULSE_MAX = 4
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic safe_stop_channel_a,
    input wire logic safe_stop_channel_b,
    input wire logic pwm_running,
    input wire logic err_ack,
    input wire logic sensor_supply_en,
    input wire logic driver_supply_en,
    input wire logic drive_ctrl_en,
    input wire logic torque_cutoff_state,
    input wire logic disc_err,
    input wire logic cutoff_pwm_err,
    input wire logic sensor_supply_output
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [31:0] lo_r;
    logic [31:0] lo_nxt;
    // cycles with a channel low, saturating at the filter limit so any
    // limit fits; merging both channels only over-counts
    always_comb
        lo_nxt = (safe_stop_channel_a && safe_stop_channel_b) ? 32'h0 :
                 (lo_r >= 32'(PULSE_MAX)) ? lo_r : lo_r + 32'h1;
    always_ff @(posedge clk)
        lo_r <= rst ? 32'h0 : lo_nxt;
    drv_off_a: assert property (torque_cutoff_state &&
        $past(torque_cutoff_state) |-> !driver_supply_en)
        else $error("driver supply on in cutoff");
    ctrl_eq_a: assert property (drive_ctrl_en == driver_supply_en)
        else $error("drive control differs from driver supply");
    sensor_dly_a: assert property (!$past(rst) |->
        sensor_supply_output == $past(sensor_supply_en))
        else $error("sensor supply does not follow request");
    disc_hold_a: assert property (disc_err && !err_ack |=> disc_err)
        else $error("discrepancy error dropped without ack");
    ack_clear_a: assert property ($fell(disc_err) ||
        $fell(cutoff_pwm_err) |-> $past(err_ack))
        else $error("error cleared without ack");
    disc_cut_a: assert property ($rose(disc_err) |->
        ##[0:40] torque_cutoff_state)
        else $error("discrepancy error without cutoff");
    tick_step_a: assert property ($changed(torque_cutoff_state) |=>
        $stable(torque_cutoff_state) [*8])
        else $error("state moved between ticks");
    pulse_filt_a: assert property ($fell(driver_supply_en) |->
        lo_r >= 32'(PULSE_MAX))
        else $error("short low pulse cut the supply");
    pwm_err_a: assert property ($rose(cutoff_pwm_err) |->
        torque_cutoff_state && $past(pwm_running))
        else $error("modulation error without cause");
endmodule : tcm_chk
bind tcm_monitor tcm_chk #(.PULSE_MAX(PULSE_MAX)) u_chk (.*);

//--- verif/tcm_monitor_tb_top.sv
// self-checking bench for the torque cutoff monitor
`timescale 1ns/1ps
module tcm_monitor_tb_top;
    logic clk = 0, rst = 1, req = 0, pulse = 0, pwm_running = 0;
    logic err_ack = 0, sensor_supply_en = 0, sens_exp, was_rst;
    logic [7:0] skew = 0;
    logic ch_a, ch_b, drv, ctrl, cut, disc, perr, sens;
    int failures = 0, cmp_count = 0, cycles = 0;
    int seed = 32'hb2fa;
    initial forever #10 clk = ~clk;
    tcm_relay rly (.clk(clk), .req(req), .pulse(pulse), .skew(skew),
        .ch_a(ch_a), .ch_b(ch_b));
    tcm_monitor #(.TICK_LEN(20), .DISC_LEN(3), .PULSE_MAX(4)) dut (
        .clk(clk), .rst(rst), .ce(1'h1), .safe_stop_channel_a(ch_a),
        .safe_stop_channel_b(ch_b), .pwm_running(pwm_running),
        .err_ack(err_ack), .sensor_supply_en(sensor_supply_en),
        .driver_supply_en(drv), .drive_ctrl_en(ctrl),
        .torque_cutoff_state(cut), .disc_err(disc),
        .cutoff_pwm_err(perr), .sensor_supply_output(sens));
    task automatic chk(input logic [4:0] got, input logic [4:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    // settled model: supply and control follow the cutoff state
    task automatic expect_st(input logic c, input logic d, input logic p);
        chk({cut, drv, ctrl, disc, perr}, {c, !c, !c, d, p});
    endtask : expect_st
    // sensor supply model and hang guard, every cycle
    always @(posedge clk)
    begin
        sens_exp = sensor_supply_en;
        was_rst = rst;
        #1 sensor_supply_en = 1'($random(seed));
        #1 if (!was_rst) chk({4'h0, sens}, {4'h0, sens_exp});
        cycles++;
        if (cycles > 3000)
        begin
            failures++;
            results();
        end
    end
    initial
    begin
        step(12);
        rst = 0;
        step(100);
        expect_st(0, 0, 0);
        pulse = 1;
        step(4); // a low of PULSE_MAX samples is the longest tolerated
        pulse = 0;
        step(100);
        expect_st(0, 0, 0);
        pwm_running = 1;
        req = 1;
        step(100);
        expect_st(1, 0, 1);
        pwm_running = 0;
        err_ack = 1;
        step(1);
        err_ack = 0;
        step(5);
        expect_st(1, 0, 0);
        req = 0;
        step(100);
        expect_st(0, 0, 0);
        skew = 20;
        req = 1;
        step(130);
        expect_st(1, 0, 0);
        req = 0;
        skew = 200;
        step(100);
        req = 1;
        step(300);
        expect_st(1, 1, 0);
        err_ack = 1;
        step(1);
        err_ack = 0;
        step(5);
        expect_st(1, 0, 0);
        req = 0;
        step(100);
        expect_st(0, 0, 0);
        results();
    end
endmodule : tcm_monitor_tb_top

//--- verif/tcm_relay.sv
// safety relay model driving both channels
`timescale 1ns/1ps
module tcm_relay (
    input  wire logic       clk,
    input  wire logic       req,
    input  wire logic       pulse,
    input  wire logic [7:0] skew,
    output logic            ch_a = 1'h1,
    output logic            ch_b = 1'h1
);
    int cnt = 0;
    // a drops at once, b lags by skew cycles; zero skew is the safe use
    always @(posedge clk)
    begin
        cnt <= req ? cnt + 1 : 0;
        ch_a <= #1 !req && !pulse;
        ch_b <= #1 !(req && cnt >= skew);
    end
endmodule : tcm_relay
